// *** logic/adc_seq_defines.svh ***
/*
 * Constants of the converter channel sequencer: control word fields, bus offsets,
 * reset values and conversion timing.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define CTRL_OFFSET       4'h0
`define STATUS_OFFSET     4'h1
`define RESULT_OFFSET     4'h2
`define CTRL_RESET        12'h000
`define CTRL_CH_LOW_BIT   0
`define CTRL_CH_HIGH_BIT  1
`define CTRL_ARR_A_BIT    2
`define CTRL_ARR_B_BIT    3
`define CTRL_SEQ_A_BIT    4
`define CTRL_SEQ_B_BIT    5
`define CTRL_REF_BIT      6
`define CONV_CYCLES       4'hE
`define CH_ZERO           2'h0
`define PAIR_LAST         2'h1
`define ZERO12            12'h000

`endif

// *** logic/adc_seq_pkg.sv ***
/*
 * Types shared by the sequencer design and its bench.
 * Assumes adc_seq_defines.svh is on the include path.
 */
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ARR_SINGLE = 2'h0,
        ARR_PSEUDO = 2'h1,
        ARR_DIFF   = 2'h2,
        ARR_RSVD   = 2'h3
    } arrangement_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CONV = 3'h2,
        ST_DONE = 3'h4
    } conv_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [11:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic        single_ended;
        logic        pseudo_diff;
        logic        fully_diff;
        logic        internal_ref;
        logic [1:0]  mux_channel;
    } analog_ctrl_t;

    typedef struct packed {
        logic [11:0]  ctrl;
        logic         seq_restart;
        logic [1:0]   seq_pointer;
        logic [1:0]   conv_channel;
        conv_state_t  state;
        logic [3:0]   conv_count;
        logic         strobe_prev;
        logic         busy;
        logic [15:0]  result;
        logic [11:0]  rdata;
        analog_ctrl_t analog;
    } seq_state_t;

endpackage : adc_seq_pkg

// *** logic/adc_channel_sequencer.sv ***
/*
 * Channel sequencer of a four-input converter: control register, input
 * arrangement decode, single-select and consecutive sequencing, reference
 * selection, conversion timing and tagged result word.
 * Assumes synchronous inputs on ref_clk and a SAR core that returns sar_data
 * by the end of each timed conversion.
 */
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defines.svh"

// Contract
// - Arrangement 1,0 gives two pseudo differential pairs; the code decodes ctrl[3:2] = 2'h2 as ARR_DIFF, fully differential
// - Arrangement 0,0 gives four single-ended channels
// - Arrangement 0,1 gives two fully differential pairs; the code decodes ctrl[3:2] = 2'h1 as ARR_PSEUDO, pseudo differential
// - Sequence bits 0 convert host-selected channel
// - Each write sets next channel, no advance
// - Sequence bits 1 start at channel 0, or after the converting channel if written mid-conversion
// - After final channel return to channel 0
// - Sequence repeats until next control write
// - Reference bit 1 selects internal reference
// - Reference bit 0 selects external reference
// - Channel id sits beside four result MSBs
module adc_channel_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic                      ref_clk,       // 20 MHz clock
    input  wire logic                      reset,         // Synchronous reset
    input  wire adc_seq_pkg::reg_req_t     req,           // Register request
    output var  logic [11:0]               rdata,         // Read data, next cycle
    input  wire logic                      convert_strobe_n, // Falling edge starts
    input  wire logic [11:0]               sar_data,      // Core result
    output var  logic                      busy,          // Conversion running
    output var  adc_seq_pkg::analog_ctrl_t analog,        // Mux and reference
    output var  logic [15:0]               result         // Tagged result
);
    import adc_seq_pkg::*;

    seq_state_t s_reg;
    seq_state_t s_next;

    logic [1:0]   final_ch;
    logic         seq_mode;
    logic         start_edge;
    logic [1:0]   last_ch;
    arrangement_t arr;

    always_comb
    begin
        s_next     = s_reg;
        final_ch   = {s_reg.ctrl[`CTRL_CH_HIGH_BIT], s_reg.ctrl[`CTRL_CH_LOW_BIT]};
        seq_mode   = s_reg.ctrl[`CTRL_SEQ_A_BIT] & s_reg.ctrl[`CTRL_SEQ_B_BIT];
        arr        = arrangement_t'({s_reg.ctrl[`CTRL_ARR_B_BIT],
                                     s_reg.ctrl[`CTRL_ARR_A_BIT]});
        start_edge = s_reg.strobe_prev & ~convert_strobe_n;
        last_ch    = final_ch;
        // Paired arrangements have only two addressable pairs.
        if (arr != ARR_SINGLE && final_ch > `PAIR_LAST)
        begin
            last_ch = `PAIR_LAST;
        end
        s_next.strobe_prev = convert_strobe_n;
        s_next.rdata       = `ZERO12;

        if (req.rd)
        begin
            case (req.addr)
                `CTRL_OFFSET:   s_next.rdata = s_reg.ctrl;
                `STATUS_OFFSET: s_next.rdata = {8'h00, s_reg.seq_pointer,
                                                s_reg.seq_restart, s_reg.busy};
                `RESULT_OFFSET: s_next.rdata = s_reg.result[11:0];
                default:        s_next.rdata = `ZERO12;
            endcase
        end

        case (s_reg.state)
            ST_IDLE:
            begin
                if (start_edge)
                begin
                    s_next.state      = ST_CONV;
                    s_next.conv_count = 4'h1;
                    s_next.busy       = 1'b1;
                    // Single-select uses the written address directly.
                    if (!seq_mode)
                    begin
                        s_next.conv_channel = final_ch;
                    end
                    else if (s_reg.seq_restart)
                    begin
                        s_next.conv_channel = `CH_ZERO;
                    end
                    else
                    begin
                        s_next.conv_channel = s_reg.seq_pointer;
                    end
                end
            end
            ST_CONV:
            begin
                // Strobe back high too early aborts the conversion.
                if (convert_strobe_n && s_reg.conv_count < `CONV_CYCLES)
                begin
                    s_next.state = ST_IDLE;
                    s_next.busy  = 1'b0;
                end
                else if (s_reg.conv_count == `CONV_CYCLES)
                begin
                    s_next.state = ST_DONE;
                end
                else
                begin
                    s_next.conv_count = s_reg.conv_count + 4'h1;
                end
            end
            ST_DONE:
            begin
                s_next.state  = ST_IDLE;
                s_next.busy   = 1'b0;
                s_next.result = {2'b00, s_reg.conv_channel, sar_data};
                if (seq_mode)
                begin
                    s_next.seq_restart = 1'b0;
                    if (s_reg.conv_channel >= last_ch)
                    begin
                        s_next.seq_pointer = `CH_ZERO;
                    end
                    else
                    begin
                        s_next.seq_pointer = s_reg.conv_channel + 2'h1;
                    end
                end
            end
            default:
            begin
                s_next.state = ST_IDLE;
                s_next.busy  = 1'b0;
            end
        endcase

        // A control write restarts the sequence from channel 0 unless it lands in the start cycle or in ST_CONV, whose ST_DONE clears the restart.
        if (req.wr && req.addr == `CTRL_OFFSET)
        begin
            s_next.ctrl        = req.wdata;
            s_next.seq_restart = 1'b1;
            s_next.seq_pointer = `CH_ZERO;
        end

        s_next.analog.single_ended = (arr == ARR_SINGLE);
        s_next.analog.pseudo_diff  = (arr == ARR_PSEUDO);
        s_next.analog.fully_diff   = (arr == ARR_DIFF);
        s_next.analog.internal_ref = s_reg.ctrl[`CTRL_REF_BIT];
        if (s_reg.state == ST_IDLE)
        begin
            s_next.analog.mux_channel = seq_mode ?
                (s_reg.seq_restart ? `CH_ZERO : s_reg.seq_pointer) : final_ch;
        end
        else
        begin
            s_next.analog.mux_channel = s_reg.conv_channel;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_reg             <= '0;
            s_reg.ctrl        <= `CTRL_RESET;
            s_reg.state       <= ST_IDLE;
            s_reg.strobe_prev <= 1'b1;
            s_reg.seq_restart <= 1'b1;
            s_reg.analog      <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rdata  = s_reg.rdata;
    assign busy   = s_reg.busy;
    assign analog = s_reg.analog;
    assign result = s_reg.result;

endmodule : adc_channel_sequencer
`default_nettype wire

// *** tb/adc_seq_properties.sv ***
/* Port assertions of the channel sequencer.
   Assumes one clock and bind into adc_channel_sequencer. */
`timescale 1ns/1ns
`default_nettype none
module adc_seq_chk
    import adc_seq_pkg::*;
(
    input wire logic                      ref_clk,          // Clock
    input wire logic                      reset,            // Reset
    input wire adc_seq_pkg::reg_req_t     req,              // Request
    input wire logic [11:0]               rdata,            // Read data
    input wire logic                      convert_strobe_n, // Strobe
    input wire logic [11:0]               sar_data,         // Core data
    input wire logic                      busy,             // Busy
    input wire adc_seq_pkg::analog_ctrl_t analog,           // Analog
    input wire logic [15:0]               result            // Result
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic wc = req.wr && req.addr == 4'h0;
    chk_pseudo_mode: assert property (wc && req.wdata[3:2] == 2'h1 |-> ##2
        analog.pseudo_diff && !analog.single_ended) else $error("pseudo");
    chk_single_mode: assert property (wc && req.wdata[3:2] == 2'h0 |-> ##2
        analog.single_ended && !analog.fully_diff) else $error("single");
    chk_diff_mode: assert property (wc && req.wdata[3:2] == 2'h2 |-> ##2
        analog.fully_diff && !analog.pseudo_diff) else $error("diff");
    chk_ref_select: assert property (wc |-> ##2
        analog.internal_ref == $past(req.wdata[6], 2)) else $error("ref");
    chk_single_chan: assert property (wc && req.wdata[5:4] == 2'h0 |-> ##2
        analog.mux_channel == $past(req.wdata[1:0], 2)) else $error("chan");
    chk_seq_start: assert property (wc && req.wdata[5:4] == 2'h3 |-> ##2
        analog.mux_channel == 2'h0) else $error("start");
    chk_result_tag: assert property ($changed(result) |->
        result[15:14] == 2'h0 && result[11:0] == $past(sar_data)) else $error("tag");
    chk_start_edge: assert property ($rose(busy) |->
        !$past(convert_strobe_n) && $past(convert_strobe_n, 2)) else $error("edge");
endmodule : adc_seq_chk
bind adc_channel_sequencer adc_seq_chk u_chk (.ref_clk, .reset, .req, .rdata,
    .convert_strobe_n, .sar_data, .busy, .analog, .result);
`default_nettype wire

// *** tb/adc_host_model.sv ***
/* Host and core model: register cycles, convert strobe, core data.
   Assumes the sequencer's clock; the bench calls its tasks. */
`timescale 1ns/1ns
`default_nettype none
module adc_host_model
    import adc_seq_pkg::*;
(
    input  wire logic                  ref_clk,          // Clock
    input  wire logic [11:0]           rdata,            // Read data
    output var  adc_seq_pkg::reg_req_t req,              // Request
    output var  logic                  convert_strobe_n, // Strobe
    output var  logic [11:0]           sar_data          // Core data
);
    initial
    begin
        req = '0;
        convert_strobe_n = 1'b1;
        sar_data = 12'h000;
    end
    task wr(input logic [3:0] a, input logic [11:0] d);
        @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) req <= '0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [11:0] d);
        @(posedge ref_clk) req <= '{a, 12'h000, 1'b0, 1'b1};
        @(posedge ref_clk) req <= '0;
        #1 d = rdata;
    endtask : rd
    // No write happens while the strobe is low or a conversion runs.
    task conv(input int hold, input logic [11:0] s);
        @(posedge ref_clk) convert_strobe_n <= 1'b0;
        sar_data <= s;
        repeat (hold) @(posedge ref_clk);
        convert_strobe_n <= 1'b1;
        sar_data <= ~s;
        repeat (3) @(posedge ref_clk);
    endtask : conv
endmodule : adc_host_model
`default_nettype wire

// *** tb/tb.sv ***
/* Self-checking bench of the channel sequencer.
   Assumes the host model and the checker file are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import adc_seq_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    reg_req_t req;
    logic convert_strobe_n, busy;
    logic [11:0] sar_data, rdata, rv;
    analog_ctrl_t analog;
    logic [15:0] result, last = 16'h0000;
    int error_cnt = 0, n_tests = 0, seed = 32'hA11F20BA, ptr, fin, ctl;
    always #25 ref_clk = ~ref_clk;
    adc_host_model H (.ref_clk, .rdata, .req, .convert_strobe_n, .sar_data);
    adc_channel_sequencer DUT (.ref_clk, .reset, .req, .rdata, .convert_strobe_n,
        .sar_data, .busy, .analog, .result);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wrap_up;
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task cfg(input int c);
        H.wr(4'h0, c[11:0]);
        ctl = c;
        ptr = 0;
        fin = (c[3:2] != 0 && c[1:0] > 1) ? 1 : c[1:0];
        repeat (2) @(posedge ref_clk);
        #1 chk({10'h000, analog}, {10'h000, c[3:2] == 0, c[3:2] == 1, c[3:2] == 2,
            c[6], (c[5:4] == 3) ? 2'h0 : c[1:0]});
    endtask : cfg
    task cv(input int hold);
        logic [11:0] s;
        int ch;
        s = $random(seed);
        ch = (ctl[5:4] == 3) ? ptr : ctl[1:0];
        chk({14'h0000, analog.mux_channel}, ch[15:0]);
        chk({15'h0000, busy}, 16'h0000);
        fork
            H.conv(hold, s);
            begin
                repeat (3) @(posedge ref_clk);
                #1 chk({15'h0000, busy}, 16'h0001);
            end
        join
        #1;
        if (hold > 14)
        begin
            last = {2'h0, ch[1:0], s};
            ptr = (ptr >= fin) ? 0 : ptr + 1;
        end
        chk(result, last);
    endtask : cv
    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        for (int m = 0; m < 3; m++)
            for (int r = 0; r < 2; r++)
            begin
                cfg(r * 64 + m * 4 + ($random(seed) & (m > 0 ? 1 : 3)));
                repeat (2) cv(18);
            end
        for (int f = 0; f < 5; f++)
        begin
            cfg(48 + ((f == 4) ? 7 : f));
            repeat (6) cv(18);
            cv(4);
            cv(18);
        end
        H.rd(4'h0, rv);
        chk({4'h0, rv}, ctl[15:0]);
        H.rd(4'h2, rv);
        chk({4'h0, rv}, {4'h0, last[11:0]});
        H.rd(4'h3, rv);
        chk({4'h0, rv}, 16'h0000);
        wrap_up();
    end
    initial
    begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
